// File: hdl/channel_datapath.sv
// one output channel: bypass, column offset correction, pattern substitution
`timescale 1ns/1ps
module channel_datapath
   import sensor_cfg_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst_n, // async reset, active low
   input wire sensor_cfg_pkg::ch_cfg_s cfg, // channel controls
   input wire logic in_valid, // converter sample valid
   input wire logic [9:0] in_sample, // converter sample
   input wire logic [9:0] col_offset, // column correction term
   output logic out_valid, // processed sample valid
   output logic [9:0] out_sample // processed sample
);
   logic [9:0] corr;

   // subtract the column offset, clamp at zero
   always_comb
   begin
      corr = (in_sample > col_offset) ? in_sample - col_offset : '0;
   end

   // substitution first, then bypass, then optional correction
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_valid <= 1'b0;
         out_sample <= '0;
      end
      else
      begin
         out_valid <= in_valid;
         if (in_valid)
         begin
            if (cfg.subst)
               out_sample <= cfg.pattern;
            else if (cfg.bypass)
               out_sample <= in_sample;
            else if (cfg.fpn_en)
               out_sample <= corr;
            else
               out_sample <= in_sample;
         end
      end
   end

   a_subst: assert property (p_subst)
      else $error("substituted sample differs from pattern");
   property p_subst;
      @(posedge clock) disable iff (!rst_n)
      (in_valid && cfg.subst) |=> (out_valid && out_sample == $past(cfg.pattern));
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypassed sample was modified");
   property p_bypass;
      @(posedge clock) disable iff (!rst_n)
      (in_valid && !cfg.subst && cfg.bypass) |=> out_sample == $past(in_sample);
   endproperty
   a_fpn: assert property (p_fpn)
      else $error("correction not applied");
   property p_fpn;
      @(posedge clock) disable iff (!rst_n)
      (in_valid && !cfg.subst && !cfg.bypass && cfg.fpn_en)
      |=> out_sample == $past(corr);
   endproperty
endmodule

// File: hdl/pixel_skip.sv
// subsampling keep mask: colour keeps pairs, monochrome keeps alternate
`timescale 1ns/1ps
module pixel_skip
   import sensor_cfg_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic line_start, // restarts the pattern
   input wire logic pixel_step, // one pixel passes
   input wire logic enable, // subsampling on
   input wire logic color, // colour scheme select
   output logic keep // current pixel is read
);
   logic [1:0] phase_r;

   // phase counter across the line
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         phase_r <= '0;
      else if (line_start)
         phase_r <= '0;
      else if (pixel_step)
         phase_r <= phase_r + 2'h1;
   end

   // 1:1:0:0 uses phase bit one, 1:0:1:0 uses bit zero
   always_comb
   begin
      if (!enable)
         keep = 1'b1;
      else if (color)
         keep = !phase_r[1];
      else
         keep = !phase_r[0];
   end

   a_mono: assert property (p_mono)
      else $error("monochrome skip pattern broken");
   property p_mono;
      @(posedge clock) disable iff (!rst_n)
      (enable && !color && pixel_step && !line_start && keep
       && $stable(enable) && $stable(color))
      |=> !keep;
   endproperty
endmodule

// File: hdl/sensor_cfg_pkg.sv
// shared constants and carrier types for the sensor configuration bank
package sensor_cfg_pkg;
   // register indices; byte address is four times the index
   localparam logic [6:0] IDX_CH0_CTRL = 7'h1E;
   localparam logic [6:0] IDX_CH1_PAT = 7'h21;
   localparam logic [6:0] IDX_CH12_CTRL = 7'h36;
   localparam logic [6:0] IDX_CH12_PAT = 7'h37;
   localparam logic [6:0] IDX_CAPTURE = 7'h38;
   localparam logic [6:0] IDX_WINDOWS = 7'h39;
   localparam logic [6:0] IDX_READOUT = 7'h3A;
   localparam logic [6:0] IDX_SCALE = 7'h3B;
   localparam logic [6:0] IDX_STATUS = 7'h3C;
   localparam int NUM_CH = 13;
   localparam int ADDR_LSB = 2;
   localparam int SAMPLE_W = 10;
   // channel control fields
   localparam int BIT_BYPASS = 0;
   localparam int BIT_FPN = 1;
   localparam int BIT_SUBST = 2;
   localparam int PAT_HI_LSB = 4;
   localparam int PAT_HI_MSB = 5;
   // capture mode fields
   localparam int BIT_SEQ_EN = 0;
   localparam int BIT_MASTER = 1;
   localparam int BIT_TRIG = 2;
   localparam int BIT_SUBS = 3;
   localparam int BIT_COLOR = 4;
   localparam int BIT_DUAL = 5;
   localparam int BIT_TRIPLE = 6;
   localparam int BIT_ROWSEL = 7;
   // window count fields
   localparam int WIN_LSB = 5;
   localparam int WIN_MSB = 6;
   localparam int KEY_MSB = 4;
   localparam logic [4:0] KEY_READY = 5'h11;
   // readout option fields
   localparam int BIT_CRC = 0;
   localparam int BIT_BLACK = 1;
   localparam int BIT_CAL = 2;
   localparam int NDR_LSB = 3;
   localparam int NDR_MSB = 5;
   localparam int BIT_GRAN = 6;
   localparam int BIT_DEFER = 7;
   localparam logic [2:0] NDR_INVALID = 3'h0;
   localparam int SCALE_MSB = 3;
   // reset values, write masks and bus codes
   localparam logic [7:0] RST_CH_CTRL = 8'h00;
   localparam logic [7:0] RST_CH_PAT = 8'h00;
   localparam logic [7:0] RST_CAPTURE = 8'h02;
   localparam logic [7:0] RST_WINDOWS = 8'h10;
   localparam logic [7:0] RST_READOUT = 8'h09;
   localparam logic [7:0] RST_SCALE = 8'h00;
   localparam logic [7:0] MASK_CH_CTRL = 8'h37;
   localparam logic [7:0] MASK_WINDOWS = 8'h7F;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // sequencer controls decoded from the mode registers
   typedef struct packed {
      logic enable;
      logic master;
      logic triggered;
      logic subsample;
      logic color;
      logic dual_slope;
      logic triple_slope;
      logic row_sel_hold;
      logic [1:0] windows;
      logic crc_en;
      logic black_cols;
      logic calibrate;
      logic [2:0] ndr_frames;
      logic clock_gran;
      logic [3:0] scale;
   } seq_cfg_s;

   // one channel's data path controls
   typedef struct packed {
      logic bypass;
      logic fpn_en;
      logic subst;
      logic [9:0] pattern;
   } ch_cfg_s;
endpackage

// File: hdl/sensor_config_bank.sv
// sensor configuration register bank with AHB-Lite slave and data paths
//
// Overview of operation
// - channel bypass bit passes converter samples through unmodified
// - channel correction bit subtracts column offset from samples
// - channel substitute bit replaces samples with the test pattern
// - pattern is two control bits above eight pattern bits, reset zero
// - sequencer runs only while the enable bit is set, clear at reset; here it gates row select and integration, not pixel_keep or a running timer
// - master bit: internal integration timing; clear: three pins drive it
// - shutter bit zero pipelined, one triggered; pipelined after reset
// - subsampling pattern 1:1:0:0 for colour, 1:0:1:0 for monochrome
// - continued row select holds row select during the whole readout
// - two-bit field selects one to four active windows, one at reset
// - checksum bit, set at reset, enables CRC on data and sync channels
// - black and grey reference columns read out when bit set
// - calibration bit runs column calibration and a dummy line
// - three-bit nondestructive frame count, code 000 invalid
// - granularity bit zero counts lines, one counts scaled clocks
// - clock granularity multiplies timers by two to the scale field
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sensor_config_bank
   import sensor_cfg_pkg::*;
#(
   parameter int TIMER_W = 16 // width of the granularity timer load value
)
(
   input wire logic clock, // 50 MHz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always OKAY
   output logic [31:0] hrdata, // read data
   input wire logic [NUM_CH-1:0] adc_valid, // sample valid per channel
   input wire logic [NUM_CH*10-1:0] adc_data, // samples, channel 0 low
   input wire logic [9:0] col_offset, // column correction term
   output logic [NUM_CH-1:0] out_valid, // processed valid per channel
   output logic [NUM_CH*10-1:0] out_data, // processed samples
   input wire logic integration_time_pin_a, // slave integration pin a
   input wire logic integration_time_pin_b, // slave integration pin b
   input wire logic integration_time_pin_c, // slave integration pin c
   input wire logic line_start, // start of a readout line
   input wire logic pixel_step, // pixel clock enable
   input wire logic readout_active, // pixels are being read out
   input wire logic [TIMER_W-1:0] timer_load, // timer value to run
   input wire logic timer_start, // start the timer
   output logic row_select, // row select to the array
   output logic pixel_keep, // subsampling keep flag
   output logic integrating, // integration in progress
   output logic timer_done, // granularity timer expired, one cycle
   output sensor_cfg_pkg::seq_cfg_s seq_cfg // decoded sequencer settings
);
   logic [7:0] ctrl_r [NUM_CH];
   logic [7:0] pat_r [NUM_CH];
   logic [7:0] capture_r, windows_r, readout_r, scale_r;
   logic wr_pend_r;
   logic [6:0] wr_idx_r;
   logic [2:0] int_sync_a_r, int_sync_b_r, int_sync_c_r;
   logic [31:0] timer_cnt_r;
   logic timer_run_r;
   logic [TIMER_W+15:0] clk_scaled;
   logic keep_w;
   logic take;
   logic [6:0] rd_idx;
   logic [7:0] rd_byte;
   logic ch_hit;
   logic [3:0] ch_sel;
   logic ch_pat;
   seq_cfg_s cfg_w;
   logic [2:0] int_pins_q;
   logic ext_int;

   // bus slave: zero wait state, every transfer answers OKAY
   assign take = hsel && hready && htrans == HTRANS_NONSEQ;
   assign rd_idx = haddr[ADDR_LSB+6:ADDR_LSB];

   // address phase capture for writes
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= '0;
      end
      else if (hready)
      begin
         wr_pend_r <= take && hwrite && hsize == HSIZE_WORD;
         wr_idx_r <= rd_idx;
      end
   end

   // locate a channel register pair from an index
   function automatic logic [4:0] ch_decode(input logic [6:0] idx);
      logic [6:0] rel;
      rel = idx - IDX_CH0_CTRL;
      if (idx >= IDX_CH0_CTRL && rel < 7'(2 * NUM_CH))
         ch_decode = {1'b1, rel[4:1]};
      else
         ch_decode = 5'h0F;
   endfunction

   // channel control and pattern registers, one pair each
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            ctrl_r[i] <= RST_CH_CTRL;
            pat_r[i] <= RST_CH_PAT;
         end
      end
      else if (wr_pend_r && ch_hit)
      begin
         if (ch_pat)
            pat_r[ch_sel] <= hwdata[7:0];
         else
            ctrl_r[ch_sel] <= hwdata[7:0] & MASK_CH_CTRL;
      end
   end

   // decode of the pending write index
   always_comb
   begin
      logic [4:0] dec;
      logic [6:0] rel;
      dec = ch_decode(wr_idx_r);
      rel = wr_idx_r - IDX_CH0_CTRL;
      ch_hit = dec[4];
      ch_sel = dec[3:0];
      ch_pat = rel[0];
   end

   // sequencer mode registers
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         capture_r <= RST_CAPTURE;
         windows_r <= RST_WINDOWS;
         readout_r <= RST_READOUT;
         scale_r <= RST_SCALE;
      end
      else if (wr_pend_r)
      begin
         unique case (wr_idx_r)
            IDX_CAPTURE: capture_r <= hwdata[7:0];
            IDX_WINDOWS: windows_r <= hwdata[7:0] & MASK_WINDOWS;
            IDX_READOUT:
            begin
               // invalid frame count is refused, field keeps old code
               readout_r <= hwdata[7:0];
               if (hwdata[NDR_MSB:NDR_LSB] == NDR_INVALID)
                  readout_r[NDR_MSB:NDR_LSB] <= readout_r[NDR_MSB:NDR_LSB];
            end
            IDX_SCALE: scale_r <= {4'h0, hwdata[SCALE_MSB:0]};
            default: ;
         endcase
      end
   end

   // read mux
   always_comb
   begin
      logic [4:0] dec;
      logic [6:0] rel;
      dec = ch_decode(rd_idx);
      rel = rd_idx - IDX_CH0_CTRL;
      rd_byte = 8'h00;
      if (dec[4])
         rd_byte = rel[0] ? pat_r[dec[3:0]] : ctrl_r[dec[3:0]];
      else
      begin
         unique case (rd_idx)
            IDX_CAPTURE: rd_byte = capture_r;
            IDX_WINDOWS: rd_byte = windows_r;
            IDX_READOUT: rd_byte = readout_r;
            IDX_SCALE: rd_byte = scale_r;
            IDX_STATUS: rd_byte = {4'h0, timer_run_r, int_pins_q};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // read data registered in the address phase, valid in data phase
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else if (take && !hwrite)
         hrdata <= {24'h0, rd_byte};
   end

   // decode the mode registers into the sequencer carrier
   always_comb
   begin
      cfg_w.enable = capture_r[BIT_SEQ_EN];
      cfg_w.master = capture_r[BIT_MASTER];
      cfg_w.triggered = capture_r[BIT_TRIG];
      cfg_w.subsample = capture_r[BIT_SUBS];
      cfg_w.color = capture_r[BIT_COLOR];
      cfg_w.dual_slope = capture_r[BIT_DUAL];
      cfg_w.triple_slope = capture_r[BIT_TRIPLE];
      cfg_w.row_sel_hold = capture_r[BIT_ROWSEL];
      cfg_w.windows = windows_r[WIN_MSB:WIN_LSB];
      cfg_w.crc_en = readout_r[BIT_CRC];
      cfg_w.black_cols = readout_r[BIT_BLACK];
      cfg_w.calibrate = readout_r[BIT_CAL];
      cfg_w.ndr_frames = readout_r[NDR_MSB:NDR_LSB];
      cfg_w.clock_gran = readout_r[BIT_GRAN];
      cfg_w.scale = scale_r[SCALE_MSB:0];
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         seq_cfg <= '0;
      else
         seq_cfg <= cfg_w;
   end

   // per-channel data paths
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      ch_cfg_s ccfg;
      assign ccfg.bypass = ctrl_r[c][BIT_BYPASS];
      assign ccfg.fpn_en = ctrl_r[c][BIT_FPN];
      assign ccfg.subst = ctrl_r[c][BIT_SUBST];
      assign ccfg.pattern = {ctrl_r[c][PAT_HI_MSB:PAT_HI_LSB], pat_r[c]};
      channel_datapath u_dp (
         .clock(clock),
         .rst_n(rst_n),
         .cfg(ccfg),
         .in_valid(adc_valid[c]),
         .in_sample(adc_data[c*SAMPLE_W +: SAMPLE_W]),
         .col_offset(col_offset),
         .out_valid(out_valid[c]),
         .out_sample(out_data[c*SAMPLE_W +: SAMPLE_W])
      );
   end

   // three-stage synchronisers for integration pins
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_sync_a_r <= '0;
         int_sync_b_r <= '0;
         int_sync_c_r <= '0;
         int_pins_q <= '0;
      end
      else
      begin
         int_sync_a_r <= {int_sync_a_r[1:0], integration_time_pin_a};
         int_sync_b_r <= {int_sync_b_r[1:0], integration_time_pin_b};
         int_sync_c_r <= {int_sync_c_r[1:0], integration_time_pin_c};
         if (int_sync_a_r[2] == int_sync_a_r[1])
            int_pins_q[0] <= int_sync_a_r[1];
         if (int_sync_b_r[2] == int_sync_b_r[1])
            int_pins_q[1] <= int_sync_b_r[1];
         if (int_sync_c_r[2] == int_sync_c_r[1])
            int_pins_q[2] <= int_sync_c_r[1];
      end
   end
   assign ext_int = |int_pins_q;

   // subsampling keep flag
   pixel_skip u_skip (
      .clock(clock),
      .rst_n(rst_n),
      .line_start(line_start),
      .pixel_step(pixel_step),
      .enable(cfg_w.subsample),
      .color(cfg_w.color),
      .keep(keep_w)
   );

   // integration flag and row select, gated by sequencer enable
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         integrating <= 1'b0;
         row_select <= 1'b0;
         pixel_keep <= 1'b0;
      end
      else
      begin
         pixel_keep <= keep_w && readout_active;
         if (!cfg_w.enable)
         begin
            integrating <= 1'b0;
            row_select <= 1'b0;
         end
         else
         begin
            // master uses internal timer, slave follows the pins
            integrating <= cfg_w.master ? timer_run_r : ext_int;
            row_select <= cfg_w.row_sel_hold ? readout_active
                          : (readout_active && line_start);
         end
      end
   end

   // scaled clock count for clock granularity
   assign clk_scaled = {16'h0, timer_load} << cfg_w.scale;

   // granularity timer: counts lines or scaled clocks
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer_cnt_r <= '0;
         timer_run_r <= 1'b0;
         timer_done <= 1'b0;
      end
      else
      begin
         timer_done <= 1'b0;
         if (timer_start && cfg_w.enable)
         begin
            timer_run_r <= 1'b1;
            timer_cnt_r <= cfg_w.clock_gran ? 32'(clk_scaled)
                           : 32'(timer_load);
         end
         else if (timer_run_r)
         begin
            if (timer_cnt_r <= 32'h1 &&
                (cfg_w.clock_gran || line_start))
            begin
               timer_run_r <= 1'b0;
               timer_done <= 1'b1;
               timer_cnt_r <= '0;
            end
            else if (cfg_w.clock_gran || line_start)
               timer_cnt_r <= timer_cnt_r - 32'h1;
         end
      end
   end

   a_seq_off: assert property (p_seq_off)
      else $error("row select while sequencer disabled");
   property p_seq_off;
      @(posedge clock) disable iff (!rst_n)
      (!cfg_w.enable) |=> (!row_select && !integrating);
   endproperty
   a_rowsel: assert property (p_rowsel)
      else $error("row select dropped during readout");
   property p_rowsel;
      @(posedge clock) disable iff (!rst_n)
      (cfg_w.enable && cfg_w.row_sel_hold && readout_active) |=> row_select;
   endproperty
   a_slave: assert property (p_slave)
      else $error("slave integration does not follow pins");
   property p_slave;
      @(posedge clock) disable iff (!rst_n)
      (cfg_w.enable && !cfg_w.master) |=> integrating == $past(ext_int);
   endproperty
   a_scale: assert property (p_scale)
      else $error("clock timer not scaled");
   property p_scale;
      @(posedge clock) disable iff (!rst_n)
      (timer_start && cfg_w.enable && cfg_w.clock_gran)
      |=> timer_cnt_r == 32'($past(clk_scaled));
   endproperty
   a_ndr: assert property (p_ndr)
      else $error("invalid frame count stored");
   property p_ndr;
      @(posedge clock) disable iff (!rst_n)
      readout_r[NDR_MSB:NDR_LSB] != NDR_INVALID;
   endproperty
endmodule

// File: testbench/controller_pins_model.sv
// camera controller model driving the three integration-time pins
`timescale 1ns/1ps
module controller_pins_model
(
   input wire logic clock, // system clock
   input wire logic [2:0] level, // pin levels asked for by the bench
   output logic integration_time_pin_a, // pin a
   output logic integration_time_pin_b, // pin b
   output logic integration_time_pin_c // pin c
);
   // pins move just after a rising edge, like an external timer output
   always @(posedge clock)
   begin
      integration_time_pin_a <= level[0];
      integration_time_pin_b <= level[1];
      integration_time_pin_c <= level[2];
   end
endmodule

// File: testbench/sensor_config_bank_tb.sv
// self-checking bench for the sensor configuration bank
`timescale 1ns/1ps
module sensor_config_bank_tb;
   import sensor_cfg_pkg::*;
   logic clock = 0;
   logic rst_n = 0;
   logic hsel = 0;
   logic hwrite = 0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = '0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [NUM_CH-1:0] adc_valid = '0;
   logic [NUM_CH*10-1:0] adc_data = '0;
   logic [9:0] col_offset = '0;
   logic [NUM_CH-1:0] out_valid;
   logic [NUM_CH*10-1:0] out_data;
   logic [2:0] pins = '0;
   logic pa;
   logic pb;
   logic pc;
   seq_cfg_s seq_cfg;
   logic line_start = 0;
   logic pixel_step = 0;
   logic readout_active = 0;
   logic timer_start = 0;
   logic [15:0] timer_load = '0;
   logic row_select;
   logic pixel_keep;
   logic integrating;
   logic timer_done;
   logic [3:0] colour_keep = 4'h3; // 1:1:0:0, first pixel in bit 0
   int cyc;
   int err_count = 0;
   int n_checks = 0;

   // 50 MHz clock
   always #10 clock = ~clock;

   sensor_config_bank DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .adc_valid(adc_valid),
      .adc_data(adc_data), .col_offset(col_offset), .out_valid(out_valid),
      .out_data(out_data), .integration_time_pin_a(pa),
      .integration_time_pin_b(pb), .integration_time_pin_c(pc),
      .line_start(line_start), .pixel_step(pixel_step),
      .readout_active(readout_active), .timer_load(timer_load),
      .timer_start(timer_start), .row_select(row_select),
      .pixel_keep(pixel_keep), .integrating(integrating),
      .timer_done(timer_done), .seq_cfg(seq_cfg));

   controller_pins_model partner (.clock(clock), .level(pins),
      .integration_time_pin_a(pa), .integration_time_pin_b(pb),
      .integration_time_pin_c(pc));

   // compare and count
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // wait until the slave answers; only the watchdog ends a hang
   task automatic wait_rdy();
      @(posedge clock);
      while (hreadyout !== 1'b1)
         @(posedge clock);
   endtask

   // one single-word transfer: address phase, then data phase
   task automatic bus(input logic [6:0] idx, input logic wr,
      input logic [7:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      haddr <= {23'h0, idx, 2'h0};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      logic [31:0] v;
      bus(idx, 1'b1, d, v);
   endtask

   task automatic rc(input logic [6:0] idx, input logic [31:0] exp);
      logic [31:0] v;
      bus(idx, 1'b0, 8'h00, v);
      chk("register", exp, v);
   endtask

   // one sample through a channel, result checked a few edges later
   task automatic dp(input int ch, input logic [9:0] s,
      input logic [9:0] exp);
      @(posedge clock);
      adc_valid <= NUM_CH'(1) << ch;
      adc_data[ch*10 +: 10] <= s;
      repeat (3) @(posedge clock);
      #1;
      chk("out_valid", 32'h1, {31'h0, out_valid[ch]});
      chk("out_data", {22'h0, exp}, {22'h0, out_data[ch*10 +: 10]});
   endtask

   // one line_start pulse of one cycle
   task automatic pulse_line();
      @(posedge clock);
      line_start <= 1'b1;
      @(posedge clock);
      line_start <= 1'b0;
   endtask

   // load the granularity timer and start it for one cycle
   task automatic run_timer(input logic [15:0] v);
      @(posedge clock);
      timer_load <= v;
      timer_start <= 1'b1;
      @(posedge clock);
      timer_start <= 1'b0;
   endtask

   task automatic tdone(input string name);
      $display("test %s finished, %0d errors so far", name, err_count);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // bounded run time
   initial
   begin
      #500us;
      err_count++;
      final_report();
   end

   // main sequence
   initial
   begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      rc(IDX_CAPTURE, 32'h02);
      rc(IDX_WINDOWS, 32'h10);
      rc(IDX_READOUT, 32'h09);
      rc(IDX_CH0_CTRL, 32'h00);
      rc(IDX_CH1_PAT, 32'h00);
      rc(IDX_CH12_CTRL, 32'h00);
      rc(IDX_CH12_PAT, 32'h00);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      tdone("reset values");
      wr(IDX_WINDOWS, 8'h71);
      rc(IDX_WINDOWS, 32'h71);
      chk("windows", 32'h3, {30'h0, seq_cfg.windows});
      wr(IDX_READOUT, 8'h17);
      rc(IDX_READOUT, 32'h17);
      wr(IDX_READOUT, 8'h40);
      rc(IDX_READOUT, 32'h50);
      chk("frames", 32'h2, {29'h0, seq_cfg.ndr_frames});
      chk("granularity", 32'h1, {31'h0, seq_cfg.clock_gran});
      wr(IDX_SCALE, 8'h05);
      rc(IDX_SCALE, 32'h05);
      chk("scale", 32'h5, {28'h0, seq_cfg.scale});
      tdone("sequencer modes");
      wr(IDX_CAPTURE, 8'hFD);
      rc(IDX_CAPTURE, 32'hFD);
      chk("enable", 32'h1, {31'h0, seq_cfg.enable});
      chk("master", 32'h0, {31'h0, seq_cfg.master});
      chk("triggered", 32'h1, {31'h0, seq_cfg.triggered});
      pins <= 3'h5;
      repeat (8) @(posedge clock);
      rc(IDX_STATUS, 32'h05);
      chk("integrating", 32'h1, {31'h0, integrating});
      // readout with colour subsampling and held row select
      @(posedge clock);
      line_start <= 1'b1;
      readout_active <= 1'b1;
      @(posedge clock);
      line_start <= 1'b0;
      pixel_step <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clock);
         chk("pixel_keep", {31'h0, colour_keep[i]}, {31'h0, pixel_keep});
      end
      chk("row_select", 32'h1, {31'h0, row_select});
      @(posedge clock);
      pixel_step <= 1'b0;
      readout_active <= 1'b0;
      // clock granularity: three times two to the fifth cycles
      run_timer(16'h0003);
      cyc = 0;
      while (timer_done !== 1'b1 && cyc < 200)
      begin
         @(posedge clock);
         #1;
         cyc++;
      end
      chk("timer cycles", 32'h60, cyc);
      // line granularity: the timer ends on the second line
      wr(IDX_READOUT, 8'h10);
      run_timer(16'h0002);
      pulse_line();
      @(negedge clock);
      chk("timer_done", 32'h0, {31'h0, timer_done});
      pulse_line();
      @(negedge clock);
      chk("timer_done", 32'h1, {31'h0, timer_done});
      tdone("capture mode");
      col_offset <= 10'h010;
      wr(IDX_CH0_CTRL, 8'h01);
      dp(0, 10'h155, 10'h155);
      wr(IDX_CH0_CTRL, 8'h02);
      dp(0, 10'h100, 10'h0F0);
      wr(IDX_CH12_CTRL, 8'h34);
      wr(IDX_CH12_PAT, 8'hA5);
      dp(12, 10'h001, 10'h3A5);
      dp(0, 10'h120, 10'h110);
      rc(7'h10, 32'h0);
      tdone("data path");
      final_report();
   end
endmodule
